// [rtl/audio_serial_cfg.svh]
`ifndef AUDIO_SERIAL_CFG_SVH
`define AUDIO_SERIAL_CFG_SVH

// Register byte addresses
`define REG_CTRL 8'h00
`define REG_CLKDIV 8'h04
`define REG_STATUS 8'h08
`define REG_TXDATA 8'h0c
`define REG_RXDATA 8'h10

// Reset values and writable masks
`define CTRL_RESET 32'h0000_0000
`define CTRL_KEEP_MASK 32'h0000_01ff
`define CLKDIV_RESET 32'h0020_0303
`define CLKDIV_KEEP_MASK 32'h003f_ffff

// Sample FIFOs
`define FIFO_AW 3
`define FIFO_DEPTH 4'h8
`define FIFO_PAIR 4'h2
`define FIFO_ONE 4'h1
`define PTR_ONE 3'h1

// Word lengths in bit clocks
`define WLEN8_BITS 6'h08
`define WLEN16_BITS 6'h10
`define WLEN24_BITS 6'h18
`define SLOT_MAX 6'h3f
`define SAMPLE_ZERO 24'h00_0000

`endif

// [rtl/audio_serial_pkg.sv]
package audio_serial_pkg;

    typedef enum logic [1:0] {
        MODE_INT_MASTER,
        MODE_EXT_MASTER,
        MODE_SLAVE,
        MODE_RSVD
    } clk_mode_e;

    typedef enum logic [1:0] {
        FMT_STANDARD,
        FMT_LEFT,
        FMT_RIGHT,
        FMT_RSVD
    } frame_fmt_e;

    typedef enum logic [1:0] {
        WLEN_8,
        WLEN_16,
        WLEN_24,
        WLEN_RSVD
    } word_len_e;

    typedef struct packed {
        logic [20:0] rsvd;
        logic rx_flush;
        logic tx_flush;
        logic ws_pol;
        word_len_e wlen;
        frame_fmt_e fmt;
        clk_mode_e mode;
        logic rx_en;
        logic tx_en;
    } ctrl_s;

    typedef struct packed {
        logic [9:0] rsvd;
        logic [5:0] slot_len;
        logic [7:0] codec_div;
        logic [7:0] bit_div;
    } clkdiv_s;

    typedef struct packed {
        logic [13:0] rsvd2;
        logic rx_overflow;
        logic tx_underrun;
        logic [3:0] rsvd1;
        logic [3:0] rx_count;
        logic [3:0] rsvd0;
        logic [3:0] tx_count;
    } status_s;

endpackage

// [rtl/audio_serial_transceiver.sv]
`timescale 1ns/1ps
`include "audio_serial_cfg.svh"
module audio_serial_transceiver (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic codec_clock_in,
    output logic codec_clock_out,
    input wire logic serial_bit_clock_in,
    output logic serial_bit_clock_out,
    output logic serial_bit_clock_oe_n,
    input wire logic word_select_clock_in,
    output logic word_select_clock_out,
    output logic word_select_clock_oe_n,
    input wire logic serial_data_in,
    output logic serial_data_out
);

    audio_serial_pkg::ctrl_s ctrl_q;
    audio_serial_pkg::clkdiv_s div_q;
    audio_serial_pkg::ctrl_s wr_ctrl;
    audio_serial_pkg::status_s wr_stat;
    audio_serial_pkg::status_s status;
    logic master;
    logic run;
    logic [5:0] wlen_bits;
    logic codec_lvl;
    logic codec_prev_q;
    logic src_tick;
    logic [7:0] bdiv_cnt_q;
    logic [7:0] cdiv_cnt_q;
    logic bclk_q;
    logic bit_edge;
    logic m_rise;
    logic m_fall;
    logic bclk_lvl;
    logic bclk_prev_q;
    logic ws_lvl;
    logic sdi_lvl;
    logic rise;
    logic fall;
    logic ws_level;
    logic ch_now;
    logic ch_q;
    logic [5:0] pos_q;
    logic [5:0] rpos;
    logic [5:0] npos;
    logic nch;
    logic frame_start;
    logic [5:0] tsel;
    logic [5:0] rsel;
    logic [23:0] tx_mem [0:(1 << `FIFO_AW) - 1];
    logic [`FIFO_AW-1:0] tx_wp_q;
    logic [`FIFO_AW-1:0] tx_rp_q;
    logic [3:0] tx_cnt_q;
    logic tx_push;
    logic pop2;
    logic [23:0] load_l;
    logic [23:0] load_r;
    logic [23:0] tx_l_q;
    logic [23:0] tx_r_q;
    logic [23:0] tx_word;
    logic [23:0] rx_mem [0:(1 << `FIFO_AW) - 1];
    logic [`FIFO_AW-1:0] rx_wp_q;
    logic [`FIFO_AW-1:0] rx_rp_q;
    logic [3:0] rx_cnt_q;
    logic rx_pop;
    logic rx_push2;
    logic rx_last;
    logic [23:0] rx_sh_q;
    logic [23:0] rx_sh_d;
    logic [23:0] rx_l_q;
    logic have_l_q;
    logic under_q;
    logic over_q;
    logic ctrl_wr;
    logic stat_wr;

    // Returns {bit valid, bit index within the sample} for a bit position
    function automatic logic [5:0] bit_sel(input logic [5:0] p,
                                           input audio_serial_pkg::frame_fmt_e f,
                                           input logic [5:0] s,
                                           input logic [5:0] w);
        logic signed [7:0] k;
        logic [7:0] i;
        case (f)
            audio_serial_pkg::FMT_LEFT: k = $signed({2'b00, p});
            audio_serial_pkg::FMT_RIGHT: k = $signed({2'b00, p}) - $signed({2'b00, s})
                                             + $signed({2'b00, w});
            default: k = $signed({2'b00, p}) - 8'sd1;
        endcase
        i = {2'b00, w} - $unsigned(k) - 8'h01;
        bit_sel = {(k >= 8'sd0) && (k < $signed({2'b00, w})), i[4:0]};
    endfunction

    assign wr_ctrl = audio_serial_pkg::ctrl_s'(wdata);
    assign wr_stat = audio_serial_pkg::status_s'(wdata);
    assign ctrl_wr = wr && (addr == `REG_CTRL);
    assign stat_wr = wr && (addr == `REG_STATUS);
    assign master = (ctrl_q.mode == audio_serial_pkg::MODE_INT_MASTER) ||
                    (ctrl_q.mode == audio_serial_pkg::MODE_EXT_MASTER);
    assign run = ctrl_q.tx_en || ctrl_q.rx_en;

    always_comb begin
        case (ctrl_q.wlen)
            audio_serial_pkg::WLEN_8: wlen_bits = `WLEN8_BITS;
            audio_serial_pkg::WLEN_16: wlen_bits = `WLEN16_BITS;
            default: wlen_bits = `WLEN24_BITS;
        endcase
    end

    // Configuration registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= audio_serial_pkg::ctrl_s'(`CTRL_RESET);
            div_q <= audio_serial_pkg::clkdiv_s'(`CLKDIV_RESET);
        end else if (wr) begin
            if (addr == `REG_CTRL) begin
                ctrl_q <= audio_serial_pkg::ctrl_s'(wdata & `CTRL_KEEP_MASK);
            end
            if (addr == `REG_CLKDIV) begin
                div_q <= audio_serial_pkg::clkdiv_s'(wdata & `CLKDIV_KEEP_MASK);
            end
        end
    end

    // External codec clock is sampled, so it must stay below about a quarter of mclk
    pin_sync codec_sync (
        .mclk(mclk),
        .rst(rst),
        .din(codec_clock_in),
        .level(codec_lvl)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            codec_prev_q <= 1'b0;
        end else begin
            codec_prev_q <= codec_lvl;
        end
    end

    assign src_tick = (ctrl_q.mode == audio_serial_pkg::MODE_EXT_MASTER) ?
                      (codec_lvl && !codec_prev_q) : 1'b1;

    // Bit clock divider
    assign bit_edge = master && run && src_tick && (bdiv_cnt_q == div_q.bit_div);
    assign m_rise = bit_edge && !bclk_q;
    assign m_fall = bit_edge && bclk_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bdiv_cnt_q <= 8'h00;
            bclk_q <= 1'b0;
        end else if (!master || !run) begin
            bdiv_cnt_q <= 8'h00;
            bclk_q <= 1'b0;
        end else if (src_tick) begin
            if (bit_edge) begin
                bdiv_cnt_q <= 8'h00;
                bclk_q <= !bclk_q;
            end else begin
                bdiv_cnt_q <= bdiv_cnt_q + 8'h01;
            end
        end
    end

    // Codec clock output divider
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cdiv_cnt_q <= 8'h00;
            codec_clock_out <= 1'b0;
        end else if (!master || !run) begin
            cdiv_cnt_q <= 8'h00;
            codec_clock_out <= 1'b0;
        end else if (src_tick) begin
            if (cdiv_cnt_q == div_q.codec_div) begin
                cdiv_cnt_q <= 8'h00;
                codec_clock_out <= !codec_clock_out;
            end else begin
                cdiv_cnt_q <= cdiv_cnt_q + 8'h01;
            end
        end
    end

    // Slave pins; all three share one latency so their relation holds
    pin_sync bclk_sync (
        .mclk(mclk),
        .rst(rst),
        .din(serial_bit_clock_in),
        .level(bclk_lvl)
    );

    pin_sync ws_sync (
        .mclk(mclk),
        .rst(rst),
        .din(word_select_clock_in),
        .level(ws_lvl)
    );

    pin_sync sdi_sync (
        .mclk(mclk),
        .rst(rst),
        .din(serial_data_in),
        .level(sdi_lvl)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bclk_prev_q <= 1'b0;
        end else begin
            bclk_prev_q <= bclk_lvl;
        end
    end

    assign rise = master ? m_rise : (run && bclk_lvl && !bclk_prev_q);
    assign fall = master ? m_fall : (run && !bclk_lvl && bclk_prev_q);
    assign ws_level = master ? word_select_clock_out : ws_lvl;
    assign ch_now = ws_level ^ ctrl_q.ws_pol;

    // Bit position since the last word clock change, as seen at each rise
    always_comb begin
        if (ch_now != ch_q) begin
            rpos = 6'h00;
        end else if (pos_q == `SLOT_MAX) begin
            rpos = pos_q;
        end else begin
            rpos = pos_q + 6'h01;
        end
    end

    // Slave word clock need not be symmetric; only its changes are tracked
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pos_q <= 6'h00;
            ch_q <= 1'b1;
        end else if (rise) begin
            pos_q <= rpos;
            ch_q <= ch_now;
        end
    end

    // Prediction of the next bit lets left-justified data meet its word clock edge
    assign npos = (pos_q == div_q.slot_len - 6'h01) ? 6'h00 : pos_q + 6'h01;
    assign nch = (pos_q == div_q.slot_len - 6'h01) ? !ch_q : ch_q;
    assign frame_start = fall && !nch && (npos == 6'h00);

    // Pin outputs driven in master modes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            serial_bit_clock_out <= 1'b0;
            serial_bit_clock_oe_n <= 1'b1;
            word_select_clock_out <= 1'b0;
            word_select_clock_oe_n <= 1'b1;
        end else begin
            serial_bit_clock_out <= bclk_q ^ bit_edge;
            serial_bit_clock_oe_n <= !master;
            word_select_clock_oe_n <= !master;
            if (m_fall) begin
                word_select_clock_out <= nch ^ ctrl_q.ws_pol;
            end
        end
    end

    // Transmit FIFO
    assign tx_push = wr && (addr == `REG_TXDATA) && (tx_cnt_q < `FIFO_DEPTH);
    assign pop2 = frame_start && ctrl_q.tx_en && (tx_cnt_q >= `FIFO_PAIR);
    assign load_l = pop2 ? tx_mem[tx_rp_q] : `SAMPLE_ZERO;
    assign load_r = pop2 ? tx_mem[tx_rp_q + `PTR_ONE] : `SAMPLE_ZERO;

    always_ff @(posedge mclk) begin
        if (tx_push) begin
            tx_mem[tx_wp_q] <= wdata[23:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= 4'h0;
        end else if (ctrl_wr && wr_ctrl.tx_flush) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= 4'h0;
        end else begin
            if (tx_push) begin
                tx_wp_q <= tx_wp_q + `PTR_ONE;
            end
            if (pop2) begin
                tx_rp_q <= tx_rp_q + `PTR_ONE + `PTR_ONE;
            end
            tx_cnt_q <= tx_cnt_q + (tx_push ? `FIFO_ONE : 4'h0) - (pop2 ? `FIFO_PAIR : 4'h0);
        end
    end

    // Holding registers loaded once per frame, left word and right word in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_l_q <= `SAMPLE_ZERO;
            tx_r_q <= `SAMPLE_ZERO;
        end else if (frame_start) begin
            tx_l_q <= load_l;
            tx_r_q <= load_r;
        end
    end

    assign tx_word = nch ? tx_r_q : (frame_start ? load_l : tx_l_q);
    assign tsel = bit_sel(npos, ctrl_q.fmt, div_q.slot_len, wlen_bits);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            serial_data_out <= 1'b0;
        end else if (!ctrl_q.tx_en) begin
            serial_data_out <= 1'b0;
        end else if (fall) begin
            serial_data_out <= tsel[5] ? tx_word[tsel[4:0]] : 1'b0;
        end
    end

    // Receive shifter
    assign rsel = bit_sel(rpos, ctrl_q.fmt, div_q.slot_len, wlen_bits);
    assign rx_sh_d = ({1'b0, rsel[4:0]} == wlen_bits - 6'h01) ?
                     {23'h00_0000, sdi_lvl} : {rx_sh_q[22:0], sdi_lvl};
    assign rx_last = rise && ctrl_q.rx_en && rsel[5] && (rsel[4:0] == 5'h00);
    assign rx_push2 = rx_last && ch_now && have_l_q && (rx_cnt_q <= `FIFO_DEPTH - `FIFO_PAIR);
    assign rx_pop = rd && (addr == `REG_RXDATA) && (rx_cnt_q != 4'h0);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_sh_q <= `SAMPLE_ZERO;
            rx_l_q <= `SAMPLE_ZERO;
            have_l_q <= 1'b0;
        end else if (!ctrl_q.rx_en) begin
            have_l_q <= 1'b0;
        end else if (rise && rsel[5]) begin
            rx_sh_q <= rx_sh_d;
            if (rx_last && !ch_now) begin
                rx_l_q <= rx_sh_d;
                have_l_q <= 1'b1;
            end else if (rx_last) begin
                have_l_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rx_push2) begin
            rx_mem[rx_wp_q] <= rx_l_q;
            rx_mem[rx_wp_q + `PTR_ONE] <= rx_sh_d;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= 4'h0;
        end else if (ctrl_wr && wr_ctrl.rx_flush) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= 4'h0;
        end else begin
            if (rx_push2) begin
                rx_wp_q <= rx_wp_q + `PTR_ONE + `PTR_ONE;
            end
            if (rx_pop) begin
                rx_rp_q <= rx_rp_q + `PTR_ONE;
            end
            rx_cnt_q <= rx_cnt_q + (rx_push2 ? `FIFO_PAIR : 4'h0) - (rx_pop ? `FIFO_ONE : 4'h0);
        end
    end

    // Sticky error flags; a new event beats a clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            under_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            under_q <= (frame_start && ctrl_q.tx_en && !pop2) ||
                       (under_q && !(stat_wr && wr_stat.tx_underrun));
            over_q <= (rx_last && ch_now && have_l_q && !rx_push2) ||
                      (over_q && !(stat_wr && wr_stat.rx_overflow));
        end
    end

    always_comb begin
        status = '0;
        status.tx_count = tx_cnt_q;
        status.rx_count = rx_cnt_q;
        status.tx_underrun = under_q;
        status.rx_overflow = over_q;
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                `REG_CTRL: rdata <= ctrl_q;
                `REG_CLKDIV: rdata <= div_q;
                `REG_STATUS: rdata <= status;
                `REG_RXDATA: rdata <= rx_pop ? {8'h00, rx_mem[rx_rp_q]} : 32'h0000_0000;
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
// Three-stage synchroniser; the level moves only when stages two and three agree
module pin_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end

endmodule

// [sim/audio_serial_chk.sv]
`timescale 1ns/1ps
module audio_serial_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic codec_clock_out,
    input wire logic serial_bit_clock_out,
    input wire logic serial_bit_clock_oe_n,
    input wire logic word_select_clock_out,
    input wire logic word_select_clock_oe_n,
    input wire logic serial_data_out
);
    logic ws_p, bclk_p, seen_q, ws_chg;
    logic [5:0] slot_q, cnt_q;
    assign ws_chg = word_select_clock_out != ws_p;
    // Slot length shadowed from writes; first interval after a write may be partial
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ws_p <= 1'b0;
            bclk_p <= 1'b0;
            seen_q <= 1'b0;
            slot_q <= 6'h20;
            cnt_q <= 6'h00;
        end else begin
            ws_p <= word_select_clock_out;
            bclk_p <= serial_bit_clock_out;
            if (wr && addr == 8'h04) slot_q <= wdata[21:16];
            if (wr) seen_q <= 1'b0;
            else if (ws_chg) seen_q <= 1'b1;
            if (ws_chg) cnt_q <= 6'h01;
            else if (bclk_p && !serial_bit_clock_out) cnt_q <= cnt_q + 6'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_no_write;
        !wr ##1 !wr ##1 !wr;
    endsequence
    sequence s_tx_read;
        rd && addr == 8'h0c;
    endsequence
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data present without a read");
    chk_txdata_read: assert property (s_tx_read |=> rdata == 32'h0)
        else $error("transmit data register read back nonzero");
    chk_unmapped_read: assert property (rd && (addr > 8'h10 || addr[1:0] != 2'h0)
        |=> rdata == 32'h0)
        else $error("unmapped read nonzero");
    chk_oe_pair: assert property (serial_bit_clock_oe_n == word_select_clock_oe_n)
        else $error("clock enables disagree");
    chk_codec_slave: assert property (serial_bit_clock_oe_n |-> !codec_clock_out)
        else $error("codec clock runs while not master");
    chk_ws_on_fall: assert property (s_no_write ##1 $changed(word_select_clock_out)
        |-> $fell(serial_bit_clock_out))
        else $error("word clock moved off the bit clock fall");
    chk_sdo_on_fall: assert property (s_no_write ##1 $changed(serial_data_out)
        |-> $fell(serial_bit_clock_out))
        else $error("serial data moved off the bit clock fall");
    chk_ws_slot_len: assert property (ws_chg && seen_q && !wr |-> cnt_q == slot_q)
        else $error("word clock slot length wrong");
endmodule

// [sim/codec_model.sv]
`timescale 1ns/1ps
module codec_model #(
    parameter int SLOT = 24,
    parameter int WLEN = 16
) (
    input wire logic bclk,
    input wire logic ws,
    input wire logic sdo,
    input wire logic [1:0] fmt,
    input wire logic pol,
    output logic sdi
);
    localparam logic [15:0] RX_L = 16'h9c35;
    localparam logic [15:0] RX_R = 16'h46e1;
    logic [15:0] cap_l [0:63];
    logic [15:0] cap_r [0:63];
    logic [15:0] sh = 16'h0000;
    logic ws_q = 1'b0;
    int n = 0;
    int p = 0;
    int off;
    initial sdi = 1'b0;
    assign off = fmt == 2'h1 ? 0 : (fmt == 2'h2 ? SLOT - WLEN : 1);
    always @(posedge bclk) begin
        if (ws !== ws_q) begin
            if (ws_q === pol) begin
                cap_l[n % 64] = sh;
            end else begin
                cap_r[n % 64] = sh;
                n = n + 1;
            end
            p = 0;
            ws_q = ws;
        end else begin
            p = p + 1;
        end
        if (p >= off && p < off + WLEN) begin
            sh = {sh[14:0], sdo};
        end
    end
    // Drive just after the fall so the bit is settled a full half period
    always begin
        int k;
        @(negedge bclk);
        #1;
        k = (ws !== ws_q ? 0 : p + 1) - off;
        if (k >= 0 && k < WLEN) begin
            sdi = (ws === pol) ? RX_L[WLEN-1-k] : RX_R[WLEN-1-k];
        end else begin
            sdi = ~sdi; // Undriven bits change so a stale value cannot pass
        end
    end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
bind audio_serial_transceiver audio_serial_chk chk (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .codec_clock_out(codec_clock_out),
    .serial_bit_clock_out(serial_bit_clock_out), .serial_bit_clock_oe_n(serial_bit_clock_oe_n),
    .word_select_clock_out(word_select_clock_out),
    .word_select_clock_oe_n(word_select_clock_oe_n), .serial_data_out(serial_data_out));
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic codec_clock_in = 1'b0;
    logic [31:0] rdata, got, ctrl_v;
    logic codec_out, bclk_out, bclk_oe_n, ws_out, ws_oe_n, sdo, sdi, bclk_pin, ws_pin;
    logic [1:0] fmt = 2'h0;
    logic pol = 1'b0;
    int errors = 0;
    int checks_done = 0;
    int start, base, idx;
    always #5 mclk = ~mclk;
    always #47 codec_clock_in = ~codec_clock_in;
    // Pin level: our driver when enabled, otherwise nobody drives in master-only runs
    assign bclk_pin = bclk_oe_n ? 1'b0 : bclk_out;
    assign ws_pin = ws_oe_n ? 1'b0 : ws_out;
    audio_serial_transceiver DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .codec_clock_in(codec_clock_in),
        .codec_clock_out(codec_out), .serial_bit_clock_in(bclk_pin),
        .serial_bit_clock_out(bclk_out), .serial_bit_clock_oe_n(bclk_oe_n),
        .word_select_clock_in(ws_pin), .word_select_clock_out(ws_out),
        .word_select_clock_oe_n(ws_oe_n), .serial_data_in(sdi), .serial_data_out(sdo));
    codec_model #(.SLOT(24), .WLEN(16)) codec (.bclk(bclk_pin), .ws(ws_pin), .sdo(sdo),
        .fmt(fmt), .pol(pol), .sdi(sdi));
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        rd_reg(a, d);
        chk32(name, exp, d);
    endtask
    task automatic wait_frames(input int k);
        start = codec.n;
        for (int i = 0; i < 6000 && codec.n < start + k; i++) @(posedge mclk);
        if (codec.n < start + k) begin
            errors++;
            $display("Error frames expected %0d seen %0d", start + k, codec.n);
        end
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        errors++;
        $display("Error watchdog expired");
        give_verdict;
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(8'h00, 32'h0, "ctrl reset");
        rd_chk(8'h04, 32'h00200303, "clkdiv reset");
        rd_chk(8'h08, 32'h0, "status reset");
        rd_chk(8'h14, 32'h0, "unmapped");
        wr_reg(8'h00, 32'h600);
        // Half bit period of five mclk covers the four-cycle input sync latency
        wr_reg(8'h04, 32'h00180104);
        rd_chk(8'h04, 32'h00180104, "clkdiv");
        for (int i = 0; i < 9; i++) begin
            wr_reg(8'h0c, 32'h1);
        end
        rd_chk(8'h08, 32'h8, "tx count full");
        rd_chk(8'h0c, 32'h0, "txdata read");
        // Last pass runs external master on the codec clock with the spare format code
        for (int f = 0; f < 4; f++) begin
            fmt <= f[1:0];
            pol <= (f == 2);
            wr_reg(8'h00, 32'h600);
            wr_reg(8'h08, 32'h30000);
            if (f == 3) begin
                wr_reg(8'h04, 32'h00180100);
            end
            wr_reg(8'h0c, 32'h8123);
            wr_reg(8'h0c, 32'h7e5a);
            rd_chk(8'h08, 32'h2, "status loaded");
            ctrl_v = {23'h0, pol, 2'h1, fmt, (f == 3) ? 2'h1 : 2'h0, 2'h3};
            base = codec.n;
            wr_reg(8'h00, ctrl_v);
            wait_frames(4);
            idx = base;
            for (int i = base + 3; i >= base; i--) begin
                if (codec.cap_l[i % 64] === 16'h8123) idx = i;
            end
            chk32("tx left", 32'h8123, {16'h0, codec.cap_l[idx % 64]});
            chk32("tx right", 32'h7e5a, {16'h0, codec.cap_r[idx % 64]});
            chk32("tx zero fill", 32'h0, {16'h0, codec.cap_l[(idx + 1) % 64]});
            wr_reg(8'h00, ctrl_v | 32'h400);
            wait_frames(2);
            rd_chk(8'h10, 32'h9c35, "rx left");
            rd_chk(8'h10, 32'h46e1, "rx right");
            rd_reg(8'h08, got);
            chk32("tx underrun", 32'h1, {31'h0, got[16]});
        end
        give_verdict;
    end
endmodule
